// [logic/vdr_responder.v]
`timescale 1ns/1ps
`default_nettype none
`include "vdr_consts.vh"
module vdr_responder #(
  parameter NSVID = 16,            // SVID table depth
  parameter SVID_AW = 4,           // SVID table index width
  parameter [2:0] NMODE = 3'h6,    // mode objects per SVID
  parameter [15:0] PD_SID = 16'hFF00 // standard identifier value
) (
  input wire pclk,                 // clock
  input wire presetn,              // async reset, active low
  input wire ce,                   // clock enable
  input wire psel,                 // apb select
  input wire penable,              // apb enable
  input wire pwrite,               // apb direction
  input wire [7:0] paddr,          // apb byte address
  input wire [31:0] pwdata,        // apb write data
  output wire [31:0] prdata,       // apb read data
  output wire pready,              // apb ready
  output wire pslverr,             // apb error, unmapped address
  input wire req_valid,            // request strobe
  input wire [4:0] req_cmd,        // request command
  input wire [15:0] req_svid,      // request identifier
  output wire req_ready,           // able to take a request
  output wire rsp_valid,           // answer header strobe
  output wire [4:0] rsp_cmd,       // answered command
  output wire [1:0] rsp_type,      // ack, nak or busy
  output wire [15:0] rsp_svid,     // answered identifier
  output wire [2:0] rsp_ndo,       // data object count
  output wire obj_valid,           // object valid
  output wire [31:0] obj_data,     // object word
  output wire obj_last,            // final object
  input wire obj_ready             // link takes object
);
  localparam CW = SVID_AW + 1;
  localparam MDEPTH = NSVID * NMODE;
  localparam [CW-1:0] SVID_STEP = `VDR_SVIDS_PER_REQ;
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_HDR = 3'b010;
  localparam [2:0] ST_SEND = 3'b100;
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [2:0] ctrl_reg;
  reg restart_reg;
  reg [31:0] ama_cfg_reg;
  reg [31:0] id_hdr_reg;
  reg [31:0] cert_reg;
  reg [31:0] product_reg;
  reg [CW-1:0] svid_cnt_reg;
  reg [SVID_AW-1:0] svid_idx_reg;
  reg [2:0] mode_idx_reg;
  reg [15:0] svid_mem [0:NSVID-1];
  reg [2:0] mcnt_mem [0:NSVID-1];
  reg [31:0] mode_mem [0:MDEPTH-1];
  reg [31:0] prdata_reg;
  reg pready_reg;
  reg pslverr_reg;
  reg [2:0] state_reg;
  reg [CW-1:0] cursor_reg;
  reg [CW-1:0] start_reg;
  reg [SVID_AW-1:0] slot_reg;
  reg [2:0] nobj_reg;
  reg [2:0] obj_idx_reg;
  reg [1:0] last_type_reg;
  reg rsp_valid_reg;
  reg [4:0] rsp_cmd_reg;
  reg [1:0] rsp_type_reg;
  reg [15:0] rsp_svid_reg;
  reg [2:0] rsp_ndo_reg;
  reg obj_valid_reg;
  reg [31:0] obj_data_reg;
  reg obj_last_reg;
  wire [31:0] ama_vdo;
  wire [31:0] svid_obj;
  integer i;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign req_ready = state_reg[0];
  assign rsp_valid = rsp_valid_reg;
  assign rsp_cmd = rsp_cmd_reg;
  assign rsp_type = rsp_type_reg;
  assign rsp_svid = rsp_svid_reg;
  assign rsp_ndo = rsp_ndo_reg;
  assign obj_valid = obj_valid_reg;
  assign obj_data = obj_data_reg;
  assign obj_last = obj_last_reg;
  vdr_ama_fmt u_ama (
    .cfg(ama_cfg_reg),
    .vdo(ama_vdo)
  );
  // ----------------------------------------------------------------
  // apb register access
  // ----------------------------------------------------------------
  reg [31:0] rd_next;
  reg hit_next;
  integer waddr;
  always @* begin
    rd_next = `VDR_WORD_RESET;
    hit_next = 1'b1;
    waddr = svid_idx_reg * NMODE + mode_idx_reg;
    case (paddr)
      `VDR_OFF_CTRL: rd_next = {29'h0000000, ctrl_reg};
      `VDR_OFF_STATUS: rd_next = {{(27-CW){1'b0}}, cursor_reg,
        last_type_reg, state_reg};
      `VDR_OFF_AMA_CFG: rd_next = ama_vdo;
      `VDR_OFF_ID_HDR: rd_next = id_hdr_reg;
      `VDR_OFF_CERT: rd_next = cert_reg;
      `VDR_OFF_PRODUCT: rd_next = product_reg;
      `VDR_OFF_SVID_CNT: rd_next = {{(32-CW){1'b0}}, svid_cnt_reg};
      `VDR_OFF_SVID_IDX: rd_next = {{(32-SVID_AW){1'b0}}, svid_idx_reg};
      `VDR_OFF_SVID_DATA: rd_next = {16'h0000, svid_mem[svid_idx_reg]};
      `VDR_OFF_MODE_CNT: rd_next = {29'h0000000, mcnt_mem[svid_idx_reg]};
      `VDR_OFF_MODE_IDX: rd_next = {29'h0000000, mode_idx_reg};
      `VDR_OFF_MODE_DATA: begin
        if (waddr < MDEPTH) begin
          rd_next = mode_mem[waddr];
        end
      end
      default: hit_next = 1'b0;
    endcase
  end

  wire wr_go;
  assign wr_go = psel & penable & pready_reg & pwrite & hit_next;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `VDR_CTRL_RESET;
      restart_reg <= 1'b0;
      ama_cfg_reg <= `VDR_WORD_RESET;
      id_hdr_reg <= `VDR_WORD_RESET;
      cert_reg <= `VDR_WORD_RESET;
      product_reg <= `VDR_WORD_RESET;
      svid_cnt_reg <= {CW{1'b0}};
      svid_idx_reg <= {SVID_AW{1'b0}};
      mode_idx_reg <= 3'h0;
      prdata_reg <= `VDR_WORD_RESET;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      for (i = 0; i < NSVID; i = i + 1) begin
        svid_mem[i] <= `VDR_SVID_ZERO;
        mcnt_mem[i] <= 3'h0;
      end
      for (i = 0; i < MDEPTH; i = i + 1) begin
        mode_mem[i] <= `VDR_WORD_RESET;
      end
    end else if (ce) begin
      // one wait-free access phase after each setup cycle
      pready_reg <= psel & ~penable;
      pslverr_reg <= psel & ~penable & ~hit_next;
      restart_reg <= 1'b0;
      if (psel & ~penable) begin
        prdata_reg <= pwrite ? `VDR_WORD_RESET : rd_next;
      end
      if (wr_go) begin
        case (paddr)
          `VDR_OFF_CTRL: begin
            ctrl_reg <= pwdata[2:0];
            restart_reg <= pwdata[`VDR_CTRL_RESTART];
          end
          `VDR_OFF_AMA_CFG: ama_cfg_reg <= pwdata;
          `VDR_OFF_ID_HDR: id_hdr_reg <= pwdata;
          `VDR_OFF_CERT: cert_reg <= pwdata;
          `VDR_OFF_PRODUCT: product_reg <= pwdata;
          `VDR_OFF_SVID_CNT: begin
            if (pwdata > NSVID) begin
              svid_cnt_reg <= NSVID[CW-1:0];
            end else begin
              svid_cnt_reg <= pwdata[CW-1:0];
            end
          end
          `VDR_OFF_SVID_IDX: svid_idx_reg <= pwdata[SVID_AW-1:0];
          `VDR_OFF_SVID_DATA: svid_mem[svid_idx_reg] <= pwdata[15:0];
          `VDR_OFF_MODE_CNT: begin
            // count kept within what one answer can carry
            if (pwdata[2:0] > NMODE) begin
              mcnt_mem[svid_idx_reg] <= NMODE;
            end else begin
              mcnt_mem[svid_idx_reg] <= pwdata[2:0];
            end
          end
          `VDR_OFF_MODE_IDX: mode_idx_reg <= pwdata[2:0];
          `VDR_OFF_MODE_DATA: begin
            if (waddr < MDEPTH) begin
              mode_mem[waddr] <= pwdata;
            end
          end
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  reg found;
  reg [SVID_AW-1:0] slot_next;
  reg [CW-1:0] rem;
  reg [1:0] type_next;
  reg [2:0] nobj_next;
  reg [CW-1:0] cursor_next;
  reg ok_next;
  integer j;
  always @* begin
    found = 1'b0;
    slot_next = {SVID_AW{1'b0}};
    for (j = 0; j < NSVID; j = j + 1) begin
      if (!found && (j < svid_cnt_reg) && svid_mem[j] == req_svid) begin
        found = 1'b1;
        slot_next = j[SVID_AW-1:0];
      end
    end
    rem = svid_cnt_reg - cursor_reg;
    ok_next = 1'b0;
    nobj_next = 3'h0;
    cursor_next = cursor_reg;
    case (req_cmd)
      `VDR_CMD_IDENT: begin
        ok_next = (req_svid == PD_SID);
        nobj_next = ctrl_reg[`VDR_CTRL_AMA] ? `VDR_IDENT_OBJS_AMA :
          `VDR_IDENT_OBJS;
      end
      `VDR_CMD_SVIDS: begin
        ok_next = (req_svid == PD_SID) && (svid_cnt_reg != 0);
        if (rem >= `VDR_SVIDS_PER_REQ) begin
          nobj_next = `VDR_SVID_OBJS_MAX;
          cursor_next = cursor_reg + SVID_STEP;
        end else begin
          // remainder plus terminator: odd pads, even adds a zero object
          nobj_next = rem[3:1] + 3'h1;
          cursor_next = {CW{1'b0}};
        end
      end
      `VDR_CMD_MODES: begin
        ok_next = found && (mcnt_mem[slot_next] != 3'h0);
        nobj_next = mcnt_mem[slot_next];
      end
      default: ok_next = 1'b0;
    endcase
    if (!ctrl_reg[`VDR_CTRL_EN]) begin
      ok_next = 1'b0;
    end
    if (!ok_next) begin
      type_next = `VDR_RSP_NAK;
    end else if (ctrl_reg[`VDR_CTRL_BUSY]) begin
      type_next = `VDR_RSP_BUSY;
    end else begin
      type_next = `VDR_RSP_ACK;
    end
  end
  // ----------------------------------------------------------------
  // object selection
  // ----------------------------------------------------------------
  reg [CW:0] base;
  reg hi_ok;
  reg lo_ok;
  reg [31:0] obj_next;
  integer maddr;
  always @* begin
    // the cursor has already moved on; the answer reads from its start
    base = {1'b0, start_reg} + {{(CW-3){1'b0}}, obj_idx_reg, 1'b0};
    hi_ok = base < svid_cnt_reg;
    lo_ok = (base + 1'b1) < svid_cnt_reg;
    maddr = slot_reg * NMODE + obj_idx_reg;
    obj_next = `VDR_WORD_RESET;
    case (rsp_cmd_reg)
      `VDR_CMD_IDENT: begin
        case (obj_idx_reg)
          3'h0: obj_next = id_hdr_reg;
          3'h1: obj_next = cert_reg;
          3'h2: obj_next = product_reg;
          default: obj_next = ama_vdo;
        endcase
      end
      `VDR_CMD_SVIDS: obj_next = svid_obj;
      default: begin
        if (maddr < MDEPTH) begin
          obj_next = mode_mem[maddr];
        end
      end
    endcase
  end

  vdr_svid_pair u_pair (
    .hi_svid(svid_mem[base[SVID_AW-1:0]]),
    .hi_ok(hi_ok),
    .lo_svid(svid_mem[base[SVID_AW-1:0] + 1'b1]),
    .lo_ok(lo_ok),
    .obj(svid_obj)
  );
  // ----------------------------------------------------------------
  // answer sequencer
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      cursor_reg <= {CW{1'b0}};
      slot_reg <= {SVID_AW{1'b0}};
      start_reg <= {CW{1'b0}};
      nobj_reg <= 3'h0;
      obj_idx_reg <= 3'h0;
      last_type_reg <= `VDR_RSP_NAK;
      rsp_valid_reg <= 1'b0;
      rsp_cmd_reg <= 5'h00;
      rsp_type_reg <= `VDR_RSP_NAK;
      rsp_svid_reg <= 16'h0000;
      rsp_ndo_reg <= 3'h0;
      obj_valid_reg <= 1'b0;
      obj_data_reg <= `VDR_WORD_RESET;
      obj_last_reg <= 1'b0;
    end else if (ce) begin
      rsp_valid_reg <= 1'b0;
      if (restart_reg) begin
        cursor_reg <= {CW{1'b0}};
      end
      case (state_reg)
        ST_IDLE: begin
          if (req_valid) begin
            rsp_valid_reg <= 1'b1;
            rsp_cmd_reg <= req_cmd;
            rsp_svid_reg <= req_svid;
            rsp_type_reg <= type_next;
            last_type_reg <= type_next;
            slot_reg <= slot_next;
            start_reg <= cursor_reg;
            obj_idx_reg <= 3'h0;
            if (type_next == `VDR_RSP_ACK) begin
              nobj_reg <= nobj_next;
              rsp_ndo_reg <= nobj_next + 3'h1;
              if (req_cmd == `VDR_CMD_SVIDS && !restart_reg) begin
                cursor_reg <= cursor_next;
              end
            end else begin
              nobj_reg <= 3'h0;
              rsp_ndo_reg <= 3'h1;
            end
            state_reg <= ST_HDR;
          end
        end
        ST_HDR: begin
          if (nobj_reg == 3'h0) begin
            state_reg <= ST_IDLE;
          end else begin
            obj_valid_reg <= 1'b1;
            obj_data_reg <= obj_next;
            obj_last_reg <= (nobj_reg == 3'h1);
            obj_idx_reg <= 3'h1;
            state_reg <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (obj_ready) begin
            if (obj_last_reg) begin
              obj_valid_reg <= 1'b0;
              obj_last_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end else begin
              obj_data_reg <= obj_next;
              obj_last_reg <= (obj_idx_reg + 3'h1 == nobj_reg);
              obj_idx_reg <= obj_idx_reg + 3'h1;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // vdr_responder
`default_nettype wire

// [logic/vdr_consts.vh]
`ifndef VDR_CONSTS_VH
`define VDR_CONSTS_VH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define VDR_OFF_CTRL      8'h00
`define VDR_OFF_STATUS    8'h04
`define VDR_OFF_AMA_CFG   8'h08
`define VDR_OFF_ID_HDR    8'h0C
`define VDR_OFF_CERT      8'h10
`define VDR_OFF_PRODUCT   8'h14
`define VDR_OFF_SVID_CNT  8'h18
`define VDR_OFF_SVID_IDX  8'h1C
`define VDR_OFF_SVID_DATA 8'h20
`define VDR_OFF_MODE_CNT  8'h24
`define VDR_OFF_MODE_IDX  8'h28
`define VDR_OFF_MODE_DATA 8'h2C
// ----------------------------------------------------------------
// control bits and reset values
// ----------------------------------------------------------------
`define VDR_CTRL_EN       0
`define VDR_CTRL_AMA      1
`define VDR_CTRL_BUSY     2
`define VDR_CTRL_RESTART  3
`define VDR_CTRL_RESET    3'h0
`define VDR_WORD_RESET    32'h0000_0000
// ----------------------------------------------------------------
// adapter identity object fields
// ----------------------------------------------------------------
`define VDR_AMA_VER_MSB   31
`define VDR_AMA_VER_LSB   24
`define VDR_AMA_RSVD      12'h000
`define VDR_AMA_LOW_MSB   11
`define VDR_AMA_LOW_LSB   3
`define VDR_AMA_SS_MSB    2
`define VDR_AMA_SS_LSB    0
`define VDR_AMA_SS_BAD    2
`define VDR_AMA_SS_SAFE   3'h0
// ----------------------------------------------------------------
// commands, answers and list limits
// ----------------------------------------------------------------
`define VDR_CMD_IDENT     5'h01
`define VDR_CMD_SVIDS     5'h02
`define VDR_CMD_MODES     5'h03
`define VDR_RSP_ACK       2'h1
`define VDR_RSP_NAK       2'h2
`define VDR_RSP_BUSY      2'h3
`define VDR_SVID_ZERO     16'h0000
`define VDR_SVIDS_PER_REQ 12
`define VDR_SVID_OBJS_MAX 3'h6
`define VDR_IDENT_OBJS    3'h3
`define VDR_IDENT_OBJS_AMA 3'h4
`endif

// [logic/vdr_svid_pair.v]
`timescale 1ns/1ps
`default_nettype none
`include "vdr_consts.vh"
module vdr_svid_pair (
  input wire [15:0] hi_svid, // earlier entry of the pair
  input wire hi_ok,          // earlier entry exists
  input wire [15:0] lo_svid, // later entry of the pair
  input wire lo_ok,          // later entry exists
  output wire [31:0] obj     // packed response object
);
  // missing entries become the zero terminator
  assign obj[31:16] = hi_ok ? hi_svid : `VDR_SVID_ZERO;
  assign obj[15:0] = lo_ok ? lo_svid : `VDR_SVID_ZERO;
endmodule // vdr_svid_pair
`default_nettype wire

// [logic/vdr_ama_fmt.v]
`timescale 1ns/1ps
`default_nettype none
`include "vdr_consts.vh"
module vdr_ama_fmt (
  input wire [31:0] cfg, // adapter settings as written by software
  output wire [31:0] vdo // adapter identity object as sent
);
  wire ss_bad;
  // reserved speed codes are never sent; fall back to the plain code
  assign ss_bad = cfg[`VDR_AMA_SS_BAD];
  assign vdo[`VDR_AMA_VER_MSB:`VDR_AMA_VER_LSB] =
    cfg[`VDR_AMA_VER_MSB:`VDR_AMA_VER_LSB];
  assign vdo[23:12] = `VDR_AMA_RSVD;
  assign vdo[`VDR_AMA_LOW_MSB:`VDR_AMA_LOW_LSB] =
    cfg[`VDR_AMA_LOW_MSB:`VDR_AMA_LOW_LSB];
  assign vdo[`VDR_AMA_SS_MSB:`VDR_AMA_SS_LSB] = ss_bad ? `VDR_AMA_SS_SAFE :
    cfg[`VDR_AMA_SS_MSB:`VDR_AMA_SS_LSB];
endmodule // vdr_ama_fmt
`default_nettype wire

// [tb/vdr_responder_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "vdr_consts.vh"
// --------------------
// answer stream checks
// --------------------
module vdr_responder_asserts #(
  parameter [15:0] PD_SID = 16'hFF00 // standard id
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic ce, // enable
  input wire logic req_valid, // request
  input wire logic [4:0] req_cmd, // command
  input wire logic req_ready, // idle
  input wire logic rsp_valid, // answer
  input wire logic [4:0] rsp_cmd, // echo
  input wire logic [1:0] rsp_type, // kind
  input wire logic [15:0] rsp_svid, // id
  input wire logic [2:0] rsp_ndo, // count
  input wire logic obj_valid, // valid
  input wire logic [31:0] obj_data, // word
  input wire logic obj_last, // last
  input wire logic obj_ready // taken
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire ack = rsp_type == `VDR_RSP_ACK;
  wire svl = rsp_cmd == `VDR_CMD_SVIDS;
  property p_take; req_valid && req_ready && ce |=>
    rsp_valid && !req_ready && rsp_cmd == $past(req_cmd); endproperty
  a_take: assert property (p_take) else $error("request lost");
  property p_ndo;
    rsp_valid |-> rsp_ndo != 3'h0 && (ack || rsp_ndo == 3'h1); endproperty
  a_ndo: assert property (p_ndo) else $error("bad count");
  property p_sid; rsp_valid && svl && ack |-> rsp_svid == PD_SID; endproperty
  a_sid: assert property (p_sid) else $error("bad list id");
  property p_first; rsp_valid && ack |=> obj_valid; endproperty
  a_first: assert property (p_first) else $error("no object");
  property p_done; rsp_valid && !ack |=> req_ready && !obj_valid; endproperty
  a_done: assert property (p_done) else $error("refusal busy");
  property p_hold; obj_valid && !obj_ready |=>
    obj_valid && $stable(obj_data) && $stable(obj_last); endproperty
  a_hold: assert property (p_hold) else $error("object moved");
  property p_term; obj_valid && obj_last && ack && svl && rsp_ndo != 3'h7
    |-> obj_data[15:0] == 16'h0000; endproperty
  a_term: assert property (p_term) else $error("no end mark");
  property p_ama; obj_valid && obj_last && ack && rsp_ndo == 3'h5 &&
    rsp_cmd == `VDR_CMD_IDENT |-> obj_data[23:12] == 12'h000 &&
    !obj_data[2]; endproperty
  a_ama: assert property (p_ama) else $error("bad adapter word");
  c_list: cover property (rsp_valid && ack && svl);
  c_busy: cover property (rsp_valid && rsp_type == `VDR_RSP_BUSY);
  c_ama: cover property (obj_valid && obj_last && rsp_ndo == 3'h5);
endmodule // vdr_responder_asserts
bind vdr_responder vdr_responder_asserts #(.PD_SID(PD_SID))
  u_vdr_responder_asserts (.pclk(pclk), .presetn(presetn), .ce(ce),
  .req_valid(req_valid), .req_cmd(req_cmd), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .rsp_cmd(rsp_cmd), .rsp_type(rsp_type),
  .rsp_svid(rsp_svid), .rsp_ndo(rsp_ndo), .obj_valid(obj_valid),
  .obj_data(obj_data), .obj_last(obj_last), .obj_ready(obj_ready));
`default_nettype wire

// [tb/vdr_dfp_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "vdr_consts.vh"
// --------------------
// initiator side
// --------------------
module vdr_dfp_model (
  input wire logic pclk, // clock
  input wire logic req_ready, // idle
  input wire logic rsp_valid, // answer
  input wire logic [1:0] rsp_type, // kind
  input wire logic [2:0] rsp_ndo, // count
  input wire logic obj_valid, // valid
  input wire logic [31:0] obj_data, // word
  input wire logic obj_last, // last
  output logic req_valid, // request
  output logic [4:0] req_cmd, // command
  output logic [15:0] req_svid, // id
  output logic obj_ready // take
);
  logic [31:0] objs [0:7];
  logic [1:0] got_type;
  logic [2:0] got_ndo;
  int nobj;
  int bad;
  initial begin
    req_valid = 1'b0;
    req_cmd = 5'h1F;
    req_svid = 16'h5A5A;
    obj_ready = 1'b0;
  end
  // slow drops ready at random to stall the stream
  task automatic request(input logic [4:0] c, input logic [15:0] s,
                         input bit slow);
    int n;
    n = 0;
    nobj = 0;
    bad = 0;
    req_valid <= 1'b1;
    req_cmd <= c;
    req_svid <= s;
    do @(posedge pclk); while (!req_ready && n++ < 50);
    if (req_ready !== 1'b1) bad++;
    req_valid <= 1'b0;
    req_cmd <= ~c;
    req_svid <= ~s;
    n = 0;
    do @(posedge pclk); while (!rsp_valid && n++ < 50);
    if (rsp_valid !== 1'b1) bad++;
    got_type = rsp_type;
    got_ndo = rsp_ndo;
    obj_ready <= got_type == `VDR_RSP_ACK && (!slow || $urandom_range(1));
    n = 0;
    while (got_type == `VDR_RSP_ACK && nobj + 1 < got_ndo && n++ < 200) begin
      @(posedge pclk);
      if (obj_valid && obj_ready) begin
        objs[nobj] = obj_data;
        nobj++;
        if (obj_last !== (nobj + 1 == got_ndo)) bad++;
      end
      obj_ready <= nobj + 1 < got_ndo && (!slow || $urandom_range(1));
    end
    if (got_type == `VDR_RSP_ACK && nobj + 1 < got_ndo) bad++;
  endtask
endmodule // vdr_dfp_model
`default_nettype wire

// [tb/vdr_responder_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "vdr_consts.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin \
  num_errors++; $display("ERROR t=%0t got %h exp %h", $time, a, b); \
  end end
// --------------------
// bench top
// --------------------
module vdr_responder_tb;
  localparam logic [15:0] SID = 16'hFF00;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, obj_data, rdata, cfg, xo;
  logic req_valid, req_ready, rsp_valid, obj_valid, obj_last, obj_ready;
  logic [4:0] req_cmd, rsp_cmd;
  logic [15:0] req_svid, rsp_svid;
  logic [1:0] rsp_type;
  logic [2:0] rsp_ndo;
  logic [15:0] svids [0:15];
  logic [31:0] words [0:5];
  int num_errors, compares, cur, rem, k;
  int lens [6] = '{0, 1, 2, 3, 12, 13};
  int mlen [3] = '{6, 1, 0};
  vdr_responder #(.PD_SID(SID)) u_vdr_responder (.pclk(pclk),
    .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_svid(req_svid), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_cmd(rsp_cmd), .rsp_type(rsp_type),
    .rsp_svid(rsp_svid), .rsp_ndo(rsp_ndo), .obj_valid(obj_valid),
    .obj_data(obj_data), .obj_last(obj_last), .obj_ready(obj_ready));
  vdr_dfp_model u_vdr_dfp_model (.pclk(pclk), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_type(rsp_type), .rsp_ndo(rsp_ndo),
    .obj_valid(obj_valid), .obj_data(obj_data), .obj_last(obj_last),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_svid(req_svid),
    .obj_ready(obj_ready));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready && n++ < 20);
    if (pready !== 1'b1) num_errors++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [31:0] ama_exp(input logic [31:0] c);
    ama_exp = {c[31:24], 12'h000, c[11:3], c[2] ? 3'h0 : c[2:0]};
  endfunction
  function automatic logic [15:0] ent(input int j);
    ent = j < rem ? svids[cur + j] : 16'h0000;
  endfunction
  task automatic ask(input logic [4:0] c, input logic [15:0] s,
                     input logic [1:0] t, input logic [2:0] n);
    u_vdr_dfp_model.request(c, s, 1'($urandom_range(1)));
    `CHK(u_vdr_dfp_model.got_type, t)
    `CHK(u_vdr_dfp_model.got_ndo, n)
    `CHK(u_vdr_dfp_model.bad, 0)
    `CHK(rsp_cmd, c)
    `CHK(rsp_svid, s)
  endtask
  task automatic svid_run(input int num);
    for (int i = 0; i < num; i++) begin
      svids[i] = 16'($urandom_range(16'hFFFE)) + 16'h0001;
      apb(1'b1, `VDR_OFF_SVID_IDX, 32'(i));
      apb(1'b1, `VDR_OFF_SVID_DATA, {16'h0000, svids[i]});
    end
    apb(1'b1, `VDR_OFF_SVID_CNT, 32'(num));
    apb(1'b1, `VDR_OFF_CTRL, 32'h0000_0009);
    cur = 0;
    do begin
      rem = num - cur;
      k = rem >= 12 ? 6 : rem / 2 + 1;
      if (num == 0) ask(`VDR_CMD_SVIDS, SID, `VDR_RSP_NAK, 3'h1);
      else ask(`VDR_CMD_SVIDS, SID, `VDR_RSP_ACK, 3'(k + 1));
      apb(1'b0, `VDR_OFF_STATUS, 32'h0);
      `CHK(rdata[9:5], 5'(rem >= 12 ? cur + 12 : 0))
      for (int i = 0; i < k && num > 0; i++) begin
        xo = {ent(2 * i), ent(2 * i + 1)};
        `CHK(u_vdr_dfp_model.objs[i], xo)
      end
      cur = rem >= 12 ? cur + 12 : 0;
    end while (cur != 0);
  endtask
  task automatic print_verdict;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    print_verdict;
  end
  initial begin
    void'($urandom(84));
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `VDR_OFF_CTRL, 32'h0);
    `CHK(rdata, 32'h0000_0000)
    ask(`VDR_CMD_SVIDS, SID, `VDR_RSP_NAK, 3'h1);
    apb(1'b0, `VDR_OFF_STATUS, 32'h0);
    `CHK(rdata[4:0], 5'h11)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({rerr, rdata}, {1'b1, 32'h0000_0000})
    for (int s = 0; s < 8; s++) begin
      cfg = $urandom;
      cfg[2:0] = 3'(s);
      apb(1'b1, `VDR_OFF_AMA_CFG, cfg);
      apb(1'b0, `VDR_OFF_AMA_CFG, 32'h0);
      `CHK(rdata, ama_exp(cfg))
    end
    for (int i = 0; i < 3; i++) begin
      words[i] = $urandom;
      apb(1'b1, `VDR_OFF_ID_HDR + 8'(4 * i), words[i]);
    end
    words[3] = ama_exp(cfg);
    for (int a = 1; a >= 0; a--) begin
      apb(1'b1, `VDR_OFF_CTRL, 32'(1 + 2 * a));
      ask(`VDR_CMD_IDENT, SID, `VDR_RSP_ACK, 3'(4 + a));
      for (int i = 0; i < 3 + a; i++)
        `CHK(u_vdr_dfp_model.objs[i], words[i])
    end
    foreach (lens[l]) svid_run(lens[l]);
    apb(1'b1, `VDR_OFF_SVID_IDX, 32'h1);
    foreach (mlen[x]) begin
      apb(1'b1, `VDR_OFF_MODE_CNT, 32'(mlen[x]));
      for (int j = 0; j < mlen[x]; j++) begin
        words[j] = $urandom;
        apb(1'b1, `VDR_OFF_MODE_IDX, 32'(j));
        apb(1'b1, `VDR_OFF_MODE_DATA, words[j]);
      end
      repeat (2) begin
        if (mlen[x] == 0) ask(`VDR_CMD_MODES, svids[1], 2'h2, 3'h1);
        else ask(`VDR_CMD_MODES, svids[1], 2'h1, 3'(mlen[x] + 1));
        for (int j = 0; j < mlen[x]; j++)
          `CHK(u_vdr_dfp_model.objs[j], words[j])
      end
    end
    ask(`VDR_CMD_MODES, 16'h0000, `VDR_RSP_NAK, 3'h1);
    ask(`VDR_CMD_SVIDS, ~SID, `VDR_RSP_NAK, 3'h1);
    apb(1'b1, `VDR_OFF_CTRL, 32'h0000_0005);
    ask(`VDR_CMD_SVIDS, SID, `VDR_RSP_BUSY, 3'h1);
    ask(5'h1F, SID, `VDR_RSP_NAK, 3'h1);
    print_verdict;
  end
endmodule // vdr_responder_tb
`default_nettype wire
